// ### rtl/codec_clk_pkg.sv
/*
 * Constants, register layout and state types for the codec clock and
 * serial port control block.
 * Assumes a single 10 MHz system clock and an 8-bit register port.
 */
package codec_clk_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MISC = 8'h05;
  localparam logic [7:0] ADDR_CLOCK = 8'h06;
  localparam logic [7:0] ADDR_RATIO = 8'h07;
  localparam logic [7:0] ADDR_HELD_FIRST = 8'h0F;
  localparam logic [7:0] ADDR_HELD_LAST = 8'h1B;
  localparam int HELD_COUNT = 13;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ext_adc_clock_select;
    logic recovered_clock_tristate;
    logic reserved;
    logic update_hold;
    logic interp_filter_slow;
    logic highpass_hold;
    logic codec_port_master;
    logic aux_port_master;
  } misc_t;

  typedef struct packed {
    logic [1:0] clock_out_divide;
    logic [1:0] ref_clock_freq;
    logic pll_frame_lock;
    logic [1:0] mclk_source_select;
    logic force_pll_lock;
  } clock_ctl_t;

  typedef enum logic [1:0] {
    DIV_BY_1,
    DIV_BY_2,
    DIV_BY_4,
    MUL_BY_2
  } clk_div_t;

  typedef enum logic [1:0] {
    SRC_MANUAL_PLL,
    SRC_MANUAL_REF,
    SRC_HOLD,
    SRC_AUTO
  } src_sel_t;

  typedef enum {
    MCLK_FROM_PLL,
    MCLK_FROM_REF
  } mclk_src_t;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam misc_t MISC_RESET = 8'h00;
  localparam clock_ctl_t CLOCK_RESET = 8'h00;
  localparam logic [7:0] HELD_RESET = 8'h00;
  localparam logic [7:0] RATIO_RESET = 8'h00;
  localparam logic [6:0] RATIO_WINDOW = 7'h40;
  localparam int BIT_CLK_BIT = 2;
  localparam int FRAME_CLK_BIT = 8;
  localparam logic [2:0] PLL_FREQ_FORCED = 3'h7;

endpackage

// ### rtl/codec_clock_and_port_control.sv
/*
 * Clock source, recovered clock, serial port direction and held-update
 * control for a multichannel audio codec.
 * Assumes a host writes and reads registers on a simple strobed port
 * and that clock pins are slow against the 10 MHz system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module codec_clock_and_port_control (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Clock pins and PLL status
  input wire logic ref_clock_in_i,
  input wire logic pll_clk_i,
  input wire logic pll_unlock_i,
  input wire logic [2:0] pll_freq_code_i,
  output logic recovered_clock_out_o,
  output logic recovered_clock_out_oe_o,
  output logic mclk_from_ref_o,
  output logic [2:0] pll_freq_code_o,
  output logic ratio_valid_o,
  // PLL and converter control
  output logic pll_frame_lock_o,
  output logic pll_free_run_o,
  output logic rate_detect_en_o,
  output logic [1:0] ref_clock_freq_o,
  output logic interp_filter_slow_o,
  output logic highpass_hold_o,
  output logic [8*codec_clk_pkg::HELD_COUNT-1:0] held_regs_o,
  // Codec serial port clocks
  input wire logic codec_bit_clock_i,
  input wire logic codec_frame_clock_i,
  output logic codec_bit_clock_o,
  output logic codec_frame_clock_o,
  output logic codec_clocks_oe_o,
  // Aux serial port clocks
  input wire logic aux_bit_clock_i,
  input wire logic aux_frame_clock_i,
  output logic aux_bit_clock_o,
  output logic aux_frame_clock_o,
  output logic aux_clocks_oe_o,
  // External ADC clock
  output logic ext_adc_bit_clock_o
);
  import codec_clk_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Order: ref, pll, unlock, codec bit, codec frame, aux bit, aux frame
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic [1:0] prev_q;
  wire logic [6:0] pins_in = {aux_frame_clock_i, aux_bit_clock_i,
    codec_frame_clock_i, codec_bit_clock_i, pll_unlock_i, pll_clk_i,
    ref_clock_in_i};
  wire logic ref_s = sync2_q[0];
  wire logic pll_s = sync2_q[1];
  wire logic unlock_s = sync2_q[2];

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      prev_q <= 2'h0;
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q[1:0];
    end
  end

  wire logic ref_rise = ref_s & ~prev_q[0];
  wire logic pll_rise = pll_s & ~prev_q[1];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  misc_t misc_q;
  clock_ctl_t clk_q;
  logic [7:0] pend_q [HELD_COUNT];
  logic [7:0] held_q [HELD_COUNT];
  logic [7:0] ratio_q;

  wire logic wr_misc = reg_wr_i && (reg_addr_i == ADDR_MISC);
  wire logic wr_clock = reg_wr_i && (reg_addr_i == ADDR_CLOCK);
  wire logic in_held = (reg_addr_i >= ADDR_HELD_FIRST) &&
    (reg_addr_i <= ADDR_HELD_LAST);
  wire logic [7:0] held_idx = reg_addr_i - ADDR_HELD_FIRST;
  wire misc_t misc_wr = reg_wdata_i;
  wire misc_t misc_d = {misc_wr[7:6], 1'b0, misc_wr[4:0]};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      misc_q <= MISC_RESET;
      clk_q <= CLOCK_RESET;
    end else begin
      if (wr_misc) begin
        misc_q <= misc_d;
      end
      if (wr_clock) begin
        clk_q <= reg_wdata_i;
      end
    end
  end

  // Pending copies take writes at once; outputs follow only when free
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < HELD_COUNT; i++) begin
      if (rst_i) begin
        pend_q[i] <= HELD_RESET;
        held_q[i] <= HELD_RESET;
      end else begin
        if (reg_wr_i && in_held && (held_idx == 8'(i))) begin
          pend_q[i] <= reg_wdata_i;
        end
        if (!misc_q.update_hold) begin
          held_q[i] <= pend_q[i];
        end
      end
    end
  end

  // Read data: held registers read back what was last written
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_i)
      ADDR_MISC: rd_mux = misc_q;
      ADDR_CLOCK: rd_mux = clk_q;
      ADDR_RATIO: rd_mux = ratio_q;
      default: begin
        if (in_held) begin
          rd_mux = pend_q[held_idx[3:0]];
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Master clock source
  // ----------------------------------------------------------------
  mclk_src_t src_q;
  mclk_src_t src_d;
  wire src_sel_t sel = src_sel_t'(clk_q.mclk_source_select);

  always_comb begin
    src_d = src_q;
    case (sel)
      SRC_MANUAL_PLL: src_d = MCLK_FROM_PLL;
      SRC_MANUAL_REF: src_d = MCLK_FROM_REF;
      SRC_AUTO: src_d = unlock_s ? MCLK_FROM_REF : MCLK_FROM_PLL;
      SRC_HOLD: begin
        if (unlock_s) begin
          src_d = MCLK_FROM_REF;
        end
      end
      default: src_d = src_q;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      src_q <= MCLK_FROM_PLL;
    end else begin
      src_q <= src_d;
    end
  end

  // Sampled master clock; edges only visible if well below 5 MHz
  logic mclk_prev_q;
  logic [FRAME_CLK_BIT:0] div_q;
  wire logic mclk_lvl = (src_q == MCLK_FROM_REF) ? ref_s : pll_s;
  wire logic mclk_rise = mclk_lvl & ~mclk_prev_q;
  wire logic mclk_edge = mclk_lvl ^ mclk_prev_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mclk_prev_q <= 1'b0;
      div_q <= '0;
    end else begin
      mclk_prev_q <= mclk_lvl;
      if (mclk_rise) begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Recovered clock
  // ----------------------------------------------------------------
  logic rclk_div;
  always_comb begin
    case (clk_div_t'(clk_q.clock_out_divide))
      DIV_BY_1: rclk_div = mclk_lvl;
      DIV_BY_2: rclk_div = div_q[0];
      DIV_BY_4: rclk_div = div_q[1];
      MUL_BY_2: rclk_div = mclk_edge;
      default: rclk_div = mclk_lvl;
    endcase
  end

  // Unlock under manual PLL source shows the reference, unless forced
  wire logic ref_subst = (sel == SRC_MANUAL_PLL) && unlock_s &&
    !clk_q.force_pll_lock;
  wire logic rclk_d = ref_subst ? ref_s : rclk_div;

  // ----------------------------------------------------------------
  // Ratio measurement over 64 PLL clock periods
  // ----------------------------------------------------------------
  logic [6:0] pll_cnt_q;
  logic [8:0] ref_cnt_q;
  wire logic win_end = pll_rise && (pll_cnt_q == RATIO_WINDOW - 7'h01);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pll_cnt_q <= 7'h00;
      ref_cnt_q <= 9'h000;
      ratio_q <= RATIO_RESET;
    end else begin
      if (win_end) begin
        pll_cnt_q <= 7'h00;
        // A reference edge on the closing cycle opens the next window
        ref_cnt_q <= {8'h00, ref_rise};
        ratio_q <= ref_cnt_q[8] ? 8'hFF : ref_cnt_q[7:0];
      end else begin
        if (pll_rise) begin
          pll_cnt_q <= pll_cnt_q + 7'h01;
        end
        if (ref_rise && !ref_cnt_q[8]) begin
          ref_cnt_q <= ref_cnt_q + 9'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial port clocks
  // ----------------------------------------------------------------
  wire logic bclk_gen = div_q[BIT_CLK_BIT];
  wire logic fclk_gen = div_q[FRAME_CLK_BIT];
  wire logic codec_bclk = misc_q.codec_port_master ? bclk_gen :
    sync2_q[3];
  wire logic aux_bclk = misc_q.aux_port_master ? bclk_gen :
    sync2_q[5];

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic [8*HELD_COUNT-1:0] held_flat;
  always_comb begin
    for (int i = 0; i < HELD_COUNT; i++) begin
      held_flat[8*i +: 8] = held_q[i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      recovered_clock_out_o <= 1'b0;
      recovered_clock_out_oe_o <= 1'b0;
      mclk_from_ref_o <= 1'b0;
      pll_freq_code_o <= 3'h0;
      ratio_valid_o <= 1'b0;
      pll_frame_lock_o <= 1'b0;
      pll_free_run_o <= 1'b0;
      rate_detect_en_o <= 1'b0;
      ref_clock_freq_o <= 2'h0;
      interp_filter_slow_o <= 1'b0;
      highpass_hold_o <= 1'b0;
      held_regs_o <= '0;
      codec_bit_clock_o <= 1'b0;
      codec_frame_clock_o <= 1'b0;
      codec_clocks_oe_o <= 1'b0;
      aux_bit_clock_o <= 1'b0;
      aux_frame_clock_o <= 1'b0;
      aux_clocks_oe_o <= 1'b0;
      ext_adc_bit_clock_o <= 1'b0;
    end else begin
      if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
      end
      recovered_clock_out_o <= rclk_d;
      recovered_clock_out_oe_o <= !misc_q.recovered_clock_tristate;
      mclk_from_ref_o <= (src_q == MCLK_FROM_REF);
      pll_freq_code_o <= clk_q.force_pll_lock ? PLL_FREQ_FORCED :
        pll_freq_code_i;
      ratio_valid_o <= !clk_q.force_pll_lock;
      pll_frame_lock_o <= clk_q.pll_frame_lock;
      pll_free_run_o <= clk_q.force_pll_lock;
      rate_detect_en_o <= !clk_q.force_pll_lock;
      ref_clock_freq_o <= clk_q.ref_clock_freq;
      interp_filter_slow_o <= misc_q.interp_filter_slow;
      highpass_hold_o <= misc_q.highpass_hold;
      held_regs_o <= held_flat;
      codec_bit_clock_o <= bclk_gen;
      codec_frame_clock_o <= fclk_gen;
      codec_clocks_oe_o <= misc_q.codec_port_master;
      aux_bit_clock_o <= bclk_gen;
      aux_frame_clock_o <= fclk_gen;
      aux_clocks_oe_o <= misc_q.aux_port_master;
      ext_adc_bit_clock_o <= misc_q.ext_adc_clock_select ? codec_bclk :
        aux_bclk;
    end
  end

endmodule

`default_nettype wire

// ### sim/codec_clock_and_port_control_tb.sv
/* Self-checking bench for the codec clock control block.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module codec_clock_and_port_control_tb;
  import codec_clk_pkg::*;
  typedef struct packed {logic [7:0] a, d, rd, out;} row_t;
  // --------------------
  // Bench
  // --------------------
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic pll_unlock_i = 1'b0;
  logic [2:0] pll_freq_code_i = 3'h2;
  logic wr, rd, refc, pll, af, cf, rclk, rclk_oe, from_ref, valid, flock;
  logic frun, filt, hpf, adc, cbo, cfo, coe, abo, afo, aoe;
  logic [2:0] fcode;
  logic [7:0] addr, wdata, rdata, d;
  logic [103:0] held;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  // Slave bit clocks are held static: aux high, codec low
  wire a_b = aoe ? abo : 1'b1;
  wire a_f = aoe ? afo : af;
  wire c_b = coe ? cbo : 1'b0;
  wire c_f = coe ? cfo : cf;
  wire [7:0] flds = {rclk_oe, coe, aoe, filt, hpf, flock, frun, valid};
  row_t rows[8] = '{'{8'h05, 8'hFF, 8'hDF, 8'h79}, '{8'h05, 8'h20, 8'h00,
    8'h81}, '{8'h05, 8'h0A, 8'h0A, 8'hD1}, '{8'h06, 8'h09, 8'h09, 8'hD6},
    '{8'h30, 8'h5A, 8'h00, 8'hD6}, '{8'h06, 8'h00, 8'h00, 8'hD1},
    '{8'h05, 8'h05, 8'h05, 8'hA9}, '{8'h06, 8'h20, 8'h20, 8'hA9}};
  // Select, unlock, expected source from reference
  logic [3:0] src[8] = '{4'h5, 4'h7, 4'h2, 4'hF, 4'hC, 4'h8, 4'hB, 4'h9};
  always #50 clk_sys_i = ~clk_sys_i;
  codec_clock_and_port_control dut (.clk_sys_i, .rst_i, .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .ref_clock_in_i(refc), .pll_clk_i(pll),
    .pll_unlock_i, .pll_freq_code_i, .recovered_clock_out_o(rclk),
    .recovered_clock_out_oe_o(rclk_oe), .mclk_from_ref_o(from_ref),
    .pll_freq_code_o(fcode), .ratio_valid_o(valid),
    .pll_frame_lock_o(flock), .pll_free_run_o(frun), .rate_detect_en_o(),
    .ref_clock_freq_o(), .interp_filter_slow_o(filt),
    .highpass_hold_o(hpf), .held_regs_o(held), .codec_bit_clock_i(c_b),
    .codec_frame_clock_i(c_f), .codec_bit_clock_o(cbo),
    .codec_frame_clock_o(cfo), .codec_clocks_oe_o(coe),
    .aux_bit_clock_i(a_b), .aux_frame_clock_i(a_f), .aux_bit_clock_o(abo),
    .aux_frame_clock_o(afo), .aux_clocks_oe_o(aoe),
    .ext_adc_bit_clock_o(adc));
  host_model host (.clk_sys_i, .reg_rdata_i(rdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .ref_clock_o(refc), .pll_clk_o(pll), .aux_frame_o(af),
    .codec_frame_o(cf));
  task automatic chk(input string nm, input logic [103:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  // Counts rising edges over len cycles, sampled away from the edge
  task automatic count(input int sel, input int len, output int c);
    logic v, p;
    c = 0;
    @(negedge clk_sys_i);
    p = sel == 0 ? rclk : sel == 1 ? cbo : sel == 2 ? cfo :
      sel == 3 ? abo : afo;
    repeat (len) begin
      @(negedge clk_sys_i);
      v = sel == 0 ? rclk : sel == 1 ? cbo : sel == 2 ? cfo :
        sel == 3 ? abo : afo;
      if (v && !p) c++;
      p = v;
    end
  endtask
  task automatic test_done;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    wait_n(4);
    rst_i = 1'b0;
    wait_n(3);
    chk("reset_out", {rclk_oe, from_ref, valid, frun}, 4'hA);
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, d);
      chk("readback", d, rows[i].rd);
      chk("fields", flds, rows[i].out);
      chk("status", fcode, rows[i].out[1] ? 3'h7 : 3'h2);
    end
    for (int e = 0; e < 2; e++) begin
      host.wr(ADDR_MISC, {e[0], 7'h00});
      wait_n(4);
      chk("ext_adc", adc, !e[0]);
    end
    foreach (src[i]) begin
      pll_unlock_i = src[i][1];
      if (i == 0 || src[i][3:2] != src[i-1][3:2])
        host.wr(ADDR_CLOCK, {5'h00, src[i][3:2], 1'b0});
      wait_n(8);
      chk("mclk_src", from_ref, src[i][0]);
    end
    pll_unlock_i = 1'b1;
    for (int f = 0; f < 2; f++) begin
      host.wr(ADDR_CLOCK, {7'h00, f[0]});
      wait_n(10);
      count(0, 768, n);
      chk("rclk_src", n, f ? 64 : 96);
    end
    pll_unlock_i = 1'b0;
    for (int v = 0; v < 4; v++) begin
      host.wr(ADDR_CLOCK, {v[1:0], 6'h02});
      wait_n(10);
      count(0, 256, n);
      chk("divide", n, v == 3 ? 64 : 32 >> v);
    end
    host.wr(ADDR_MISC, 8'h02);
    wait_n(4);
    count(1, 512, n);
    chk("bit_clk", n, 8);
    count(2, 8192, n);
    chk("frame_clk", n, 2);
    count(3, 512, n);
    chk("aux_bit_clk", n, 8);
    count(4, 8192, n);
    chk("aux_frame_clk", n, 2);
    for (int k = 0; k < 2; k++) begin
      host.rd(ADDR_RATIO, d);
      chk("ratio", d, 8'h60);
      host.wr(ADDR_RATIO, 8'hFF);
    end
    host.wr(ADDR_HELD_FIRST, 8'h11);
    wait_n(4);
    chk("held", held[7:0], 8'h11);
    host.wr(ADDR_MISC, 8'h10);
    host.wr(ADDR_HELD_FIRST, 8'h33);
    host.wr(ADDR_HELD_LAST, 8'h22);
    wait_n(4);
    chk("frozen", {held[103:96], held[7:0]}, 16'h0011);
    host.rd(ADDR_HELD_FIRST, d);
    chk("pending", d, 8'h33);
    host.wr(ADDR_MISC, 8'h00);
    wait_n(4);
    chk("applied", {held[103:96], held[7:0]}, 16'h2233);
    rst_i = 1'b1;
    wait_n(4);
    rst_i = 1'b0;
    wait_n(3);
    host.rd(ADDR_CLOCK, d);
    chk("rst_clock", d, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire

// ### sim/codec_ctl_chk.sv
/* Port checker for the codec clock control block.
   Assumes one clock domain and the block's own port names. */
`timescale 1ns/1ps
`default_nettype none
module codec_ctl_chk
  import codec_clk_pkg::*;
(
  // Clock, reset, register port
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Watched outputs
  input wire logic recovered_clock_out_oe_o,
  input wire logic [2:0] pll_freq_code_o,
  input wire logic ratio_valid_o,
  input wire logic pll_frame_lock_o,
  input wire logic pll_free_run_o,
  input wire logic rate_detect_en_o,
  input wire logic interp_filter_slow_o,
  input wire logic highpass_hold_o,
  input wire logic [1:0] ref_clock_freq_o,
  input wire logic codec_clocks_oe_o,
  input wire logic aux_clocks_oe_o
);
  // --------------------
  // Properties
  // --------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [1:0] up_q;
  wire mw = reg_wr_i && reg_addr_i == ADDR_MISC;
  wire cw = reg_wr_i && reg_addr_i == ADDR_CLOCK;
  // Outputs settle two edges after release, so skip those
  wire live = up_q[1];
  always_ff @(posedge clk_sys_i) up_q <= rst_i ? 2'h0 : {up_q[0], 1'b1};
  a_oe_release: assert property (mw |-> ##2
    recovered_clock_out_oe_o == !$past(reg_wdata_i[6], 2)) else $error("hiz");
  a_codec_dir: assert property (mw |-> ##2
    codec_clocks_oe_o == $past(reg_wdata_i[1], 2)) else $error("codec dir");
  a_aux_dir: assert property (mw |-> ##2
    aux_clocks_oe_o == $past(reg_wdata_i[0], 2)) else $error("aux dir");
  a_filter_sel: assert property (mw |-> ##2
    interp_filter_slow_o == $past(reg_wdata_i[3], 2)) else $error("filter");
  a_hpf_hold: assert property (mw |-> ##2
    highpass_hold_o == $past(reg_wdata_i[2], 2)) else $error("hpf");
  a_frame_lock: assert property (cw |-> ##2
    pll_frame_lock_o == $past(reg_wdata_i[3], 2)) else $error("lock");
  a_freq_field: assert property (cw |-> ##2
    ref_clock_freq_o == $past(reg_wdata_i[5:4], 2)) else $error("freq");
  a_force_detect: assert property (live |->
    rate_detect_en_o != pll_free_run_o) else $error("detect");
  a_force_status: assert property (live && !ratio_valid_o |->
    pll_freq_code_o == PLL_FREQ_FORCED && pll_free_run_o) else $error("stat");
  a_resv_read: assert property (reg_rd_i && reg_addr_i == ADDR_MISC |=>
    reg_rdata_o[5] == 1'b0) else $error("reserved");
  c_hiz: cover property (mw && reg_wdata_i[6]);
  c_forced: cover property (live && !ratio_valid_o);
  c_ratio: cover property (reg_rd_i && reg_addr_i == ADDR_RATIO);
endmodule
bind codec_clock_and_port_control codec_ctl_chk chk_i (.clk_sys_i, .rst_i,
  .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .recovered_clock_out_oe_o, .pll_freq_code_o, .ratio_valid_o,
  .pll_frame_lock_o, .pll_free_run_o, .rate_detect_en_o,
  .interp_filter_slow_o, .highpass_hold_o, .codec_clocks_oe_o,
  .aux_clocks_oe_o, .ref_clock_freq_o);
`default_nettype wire

// ### sim/host_model.sv
/* Host controller: register port tasks and clock pin sources.
   Assumes the device takes requests on the rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Register port
  input wire logic clk_sys_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  // Clock pins
  output logic ref_clock_o,
  output logic pll_clk_o,
  output logic aux_frame_o,
  output logic codec_frame_o
);
  // --------------------
  // Sources and tasks
  // --------------------
  int cnt = 0;
  initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o, ref_clock_o,
    pll_clk_o, aux_frame_o, codec_frame_o} = '0;
  // Ratio of the two periods is 12/8, a clean 1.5
  always @(negedge clk_sys_i) begin
    cnt <= cnt + 1;
    ref_clock_o <= cnt % 8 < 4;
    pll_clk_o <= cnt % 12 < 6;
    aux_frame_o <= cnt[6];
    codec_frame_o <= cnt[7];
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge clk_sys_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(negedge clk_sys_i);
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire
